// file: inc/smp_pkg.sv
// constants for the switch mac frame policy block
package smp_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] SMP_IDX_CTRL_A = 12'h331;
  localparam logic [11:0] SMP_IDX_CTRL_B = 12'h332;
  localparam logic [11:0] SMP_IDX_RATE_LO = 12'h333;
  localparam logic [11:0] SMP_IDX_STATUS = 12'h3f0;
  localparam int          SMP_ADDR_W = 14;
  // reset values
  localparam logic [7:0] SMP_RST_CTRL_A = 8'hf0;
  localparam logic [7:0] SMP_RST_CTRL_B = 8'h00;
  localparam logic [7:0] SMP_RST_RATE_LO = 8'h4a;
  // control a field positions
  localparam int SMP_A_MC_EXCL = 6;
  localparam int SMP_A_BP_CRS = 5;
  localparam int SMP_A_FAIR = 4;
  localparam int SMP_A_NO_XCOL = 3;
  localparam int SMP_A_JUMBO = 2;
  localparam int SMP_A_MAX_DIS = 1;
  localparam int SMP_A_SHORT = 0;
  // control b field positions
  localparam int SMP_B_NULL_VID = 3;
  localparam int SMP_B_RATE_HI = 0;
  localparam int SMP_RATE_HI_W = 3;
  localparam int SMP_RATE_W = 11;
  localparam int SMP_QUOTA_SHIFT = 6;     // rate times 64 bytes
  // frame sizes in bytes
  localparam int SMP_LEN_W = 14;
  localparam logic [13:0] SMP_MIN_STD = 14'd64;
  localparam logic [13:0] SMP_MIN_SHORT = 14'd32;
  localparam logic [13:0] SMP_MAX_UNTAG = 14'd1518;
  localparam logic [13:0] SMP_MAX_TAG = 14'd1522;
  localparam logic [13:0] SMP_MAX_NOCHK = 14'd2000;
  localparam logic [13:0] SMP_JUMBO_CAP = 14'd9000;
  localparam logic [13:0] SMP_HDR_UNTAG = 14'd18;
  localparam logic [13:0] SMP_HDR_TAG = 14'd22;
  // collisions
  localparam logic [4:0] SMP_XCOL_LIMIT = 5'd16;
  // timing
  localparam int SMP_CLK_KHZ = 20000;
  localparam int SMP_PERIOD_1G_US = 5000;
  localparam int SMP_PERIOD_1G_CYC = SMP_PERIOD_1G_US * SMP_CLK_KHZ / 1000;
  localparam logic [6:0] SMP_DIV_1G = 7'd1;     // 5 ms
  localparam logic [6:0] SMP_DIV_100M = 7'd10;  // 50 ms
  localparam logic [6:0] SMP_DIV_10M = 7'd100;  // 500 ms
  // port speed codes
  typedef enum logic [1:0] {
    SMP_SPD_10   = 2'h0,
    SMP_SPD_100  = 2'h1,
    SMP_SPD_1000 = 2'h2
  } smp_speed_e;
endpackage

// file: rtl/smp_storm_port.sv
// per-port broadcast storm byte quota counter
`timescale 1ns/10ps
module smp_storm_port
  import smp_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 tick_5ms,
  input  wire logic [1:0]           speed,
  input  wire logic                 hit,
  input  wire logic [SMP_LEN_W-1:0] len,
  input  wire logic [17:0]          quota,
  output logic                      over
);
  logic [6:0]  tick_cnt_reg;
  logic [17:0] used_reg;
  logic [6:0]  div;
  logic        boundary;
  logic [18:0] sum;

  // ticks per period follow the port speed
  always_comb begin
    unique case (speed)
      SMP_SPD_1000: div = SMP_DIV_1G;
      SMP_SPD_100:  div = SMP_DIV_100M;
      default:      div = SMP_DIV_10M;
    endcase
  end

  assign boundary = tick_5ms && (tick_cnt_reg + 7'd1 >= div);
  assign sum      = {1'b0, used_reg} + {5'h00, len};

  // period divider
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= 7'h00;
    end else if (boundary) begin
      tick_cnt_reg <= 7'h00;
    end else if (tick_5ms) begin
      tick_cnt_reg <= tick_cnt_reg + 7'd1;
    end
  end

  // byte usage, restarted at each period boundary
  always_ff @(posedge clk) begin
    if (rst) begin
      used_reg <= 18'h00000;
    end else if (boundary) begin
      used_reg <= hit ? {4'h0, len} : 18'h00000;
    end else if (hit) begin
      used_reg <= sum[18] ? 18'h3ffff : sum[17:0];
    end
  end

  assign over = (used_reg >= quota);
endmodule

// file: rtl/smp_frame_policy.sv
// switch mac frame policy: size admission, vid, storm, collisions, apb
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
//
// Overview of operation
// - control bit 6 keeps multicast out of storm quota
// - control bit 5 picks carrier-sense back pressure
// - fair mode may drop non-flow-controlled frames
// - fair off: flow control only, no drops
// - bit 3 keeps retrying past sixteen collisions
// - jumbo admits payload up to programmed limit, at most 9000
// - jumbo overrides the maximum size check disable
// - check disabled admits frames up to 2000
// - standard maximum 1522 tagged, 1518 untagged
// - pass-short admits frames from 32 bytes
// - without pass-short, frames under 64 dropped
// - null vid replaced by port default vid
// - storm quota is eleven-bit rate times 64
// - storm period 5, 50, 500 ms by speed
// - rate low byte in next register, reset 0x4a
module smp_frame_policy
  import smp_pkg::*;
#(
  parameter int NPORTS       = 7,
  parameter int PERIOD_5MS_CYC = SMP_PERIOD_1G_CYC
)(
  input  wire logic                   clk,
  input  wire logic                   rst,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [SMP_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic [31:0]                 prdata,
  // per-port context
  input  wire logic [2*NPORTS-1:0]    port_speed,
  input  wire logic [12*NPORTS-1:0]   port_default_vid,
  input  wire logic [NPORTS-1:0]      port_fc_en,
  input  wire logic [SMP_LEN_W-1:0]   jumbo_limit,
  input  wire logic                   egress_shared_cong,
  // received frame descriptor
  input  wire logic                   rx_valid,
  input  wire logic [2:0]             rx_port,
  input  wire logic [SMP_LEN_W-1:0]   rx_len,
  input  wire logic                   rx_tagged,
  input  wire logic [11:0]            rx_vid,
  input  wire logic                   rx_bcast,
  input  wire logic                   rx_mcast,
  // decision
  output logic                        rx_done,
  output logic                        rx_pass,
  output logic [11:0]                 rx_vid_out,
  // half duplex and flow control
  input  wire logic                   tx_coll,
  input  wire logic [4:0]             tx_coll_cnt,
  output logic                        tx_retry,
  output logic                        tx_abort,
  output logic                        bp_carrier_mode,
  output logic [NPORTS-1:0]           fc_assert
);
  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (NPORTS < 1 || NPORTS > 8) begin : g_bad_ports
    $error("smp_frame_policy: NPORTS must be 1 to 8");
  end
  if (PERIOD_5MS_CYC < 2) begin : g_bad_period
    $error("smp_frame_policy: PERIOD_5MS_CYC must be at least 2");
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  ctrl_a_reg;
  logic [7:0]  ctrl_b_reg;
  logic [7:0]  rate_lo_reg;
  logic [7:0]  drop_cnt_reg;
  logic [11:0] idx;
  logic        hit_a;
  logic        hit_b;
  logic        hit_lo;
  logic        hit_st;
  logic        mapped;
  logic        wr_en;
  logic [31:0] rd_mux;

  assign idx    = paddr[SMP_ADDR_W-1:2];
  assign hit_a  = (idx == SMP_IDX_CTRL_A);
  assign hit_b  = (idx == SMP_IDX_CTRL_B);
  assign hit_lo = (idx == SMP_IDX_RATE_LO);
  assign hit_st = (idx == SMP_IDX_STATUS);
  assign mapped = hit_a | hit_b | hit_lo | hit_st;
  assign wr_en  = psel & penable & pwrite & mapped;

  // zero wait state; unmapped accesses report an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // control a register
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_a_reg <= SMP_RST_CTRL_A;
    end else if (wr_en && hit_a) begin
      ctrl_a_reg <= pwdata[7:0];
    end
  end

  // control b register
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_b_reg <= SMP_RST_CTRL_B;
    end else if (wr_en && hit_b) begin
      ctrl_b_reg <= pwdata[7:0];
    end
  end

  // storm rate low byte
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_lo_reg <= SMP_RST_RATE_LO;
    end else if (wr_en && hit_lo) begin
      rate_lo_reg <= pwdata[7:0];
    end
  end

  // read mux
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_a) begin
      rd_mux[7:0] = ctrl_a_reg;
    end else if (hit_b) begin
      rd_mux[7:0] = ctrl_b_reg;
    end else if (hit_lo) begin
      rd_mux[7:0] = rate_lo_reg;
    end else if (hit_st) begin
      rd_mux[7:0] = drop_cnt_reg;
    end
  end

  // read data captured in the setup phase, stable through access
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // storm period tick and per-port limiters
  // ---------------------------------------------------------------
  logic [31:0]      tick_cnt_reg;
  logic             tick_5ms;
  logic [10:0]      rate;
  logic [17:0]      quota;
  logic [NPORTS-1:0] storm_over;
  logic [NPORTS-1:0] storm_hit;

  // 5 ms base enable pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= 32'h00000000;
    end else if (tick_5ms) begin
      tick_cnt_reg <= 32'h00000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
    end
  end
  assign tick_5ms = (tick_cnt_reg == 32'(PERIOD_5MS_CYC - 1));

  assign rate  = {ctrl_b_reg[SMP_B_RATE_HI +: SMP_RATE_HI_W],
                  rate_lo_reg};
  assign quota = {1'b0, rate, {SMP_QUOTA_SHIFT{1'b0}}};

  for (genvar p = 0; p < NPORTS; p++) begin : g_storm
    smp_storm_port u_storm (
      .clk      (clk),
      .rst      (rst),
      .tick_5ms (tick_5ms),
      .speed    (port_speed[2*p +: 2]),
      .hit      (storm_hit[p]),
      .len      (rx_len),
      .quota    (quota),
      .over     (storm_over[p])
    );
  end

  // ---------------------------------------------------------------
  // frame admission
  // ---------------------------------------------------------------
  logic [SMP_LEN_W-1:0] min_len;
  logic [SMP_LEN_W-1:0] max_len;
  logic [SMP_LEN_W-1:0] jlim;
  logic [SMP_LEN_W-1:0] hdr;
  logic                 size_ok;
  logic                 storm_frame;
  logic                 port_ok;
  logic                 fair_drop;
  logic                 pre_ok;
  logic                 storm_block;
  logic                 pass_now;
  logic [11:0]          vid_now;

  // size window
  always_comb begin
    hdr  = rx_tagged ? SMP_HDR_TAG : SMP_HDR_UNTAG;
    jlim = (jumbo_limit > SMP_JUMBO_CAP) ? SMP_JUMBO_CAP : jumbo_limit;
    min_len = ctrl_a_reg[SMP_A_SHORT] ? SMP_MIN_SHORT
                                      : SMP_MIN_STD;
    if (ctrl_a_reg[SMP_A_JUMBO]) begin
      max_len = jlim + hdr;
    end else if (ctrl_a_reg[SMP_A_MAX_DIS]) begin
      max_len = SMP_MAX_NOCHK;
    end else begin
      max_len = rx_tagged ? SMP_MAX_TAG : SMP_MAX_UNTAG;
    end
    size_ok = (rx_len >= min_len) && (rx_len <= max_len);
  end

  assign port_ok = (32'(rx_port) < NPORTS);

  // frames that count toward the storm quota
  assign storm_frame = rx_bcast |
                       (rx_mcast & ~ctrl_a_reg[SMP_A_MC_EXCL]);

  // fair mode drops from non flow controlled ports sharing egress
  assign fair_drop = ctrl_a_reg[SMP_A_FAIR] & egress_shared_cong &
                     ~port_fc_en[rx_port];

  assign pre_ok      = rx_valid & port_ok & size_ok & ~fair_drop;
  assign storm_block = storm_frame & storm_over[rx_port];
  assign pass_now    = pre_ok & ~storm_block;

  // only frames actually forwarded consume quota
  always_comb begin
    storm_hit = '0;
    if (pass_now && storm_frame) begin
      storm_hit[rx_port] = 1'b1;
    end
  end

  // null vid replacement
  assign vid_now = (rx_vid == 12'h000 && ctrl_b_reg[SMP_B_NULL_VID])
                   ? port_default_vid[12*rx_port +: 12]
                   : rx_vid;

  // decision outputs, one cycle after the descriptor
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_done    <= 1'b0;
      rx_pass    <= 1'b0;
      rx_vid_out <= 12'h000;
    end else begin
      rx_done <= rx_valid;
      if (rx_valid) begin
        rx_pass    <= pass_now;
        rx_vid_out <= vid_now;
      end
    end
  end

  // dropped frame count, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      drop_cnt_reg <= 8'h00;
    end else if (rx_valid && !pass_now && drop_cnt_reg != 8'hff) begin
      drop_cnt_reg <= drop_cnt_reg + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // half duplex collisions and flow control
  // ---------------------------------------------------------------
  // retry or abort after a collision
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_retry <= 1'b0;
      tx_abort <= 1'b0;
    end else begin
      tx_retry <= tx_coll & ((tx_coll_cnt < SMP_XCOL_LIMIT) |
                             ctrl_a_reg[SMP_A_NO_XCOL]);
      tx_abort <= tx_coll & (tx_coll_cnt >= SMP_XCOL_LIMIT) &
                  ~ctrl_a_reg[SMP_A_NO_XCOL];
    end
  end

  // back pressure style and flow control assertion
  always_ff @(posedge clk) begin
    if (rst) begin
      bp_carrier_mode <= 1'b1;
      fc_assert       <= '0;
    end else begin
      bp_carrier_mode <= ctrl_a_reg[SMP_A_BP_CRS];
      fc_assert       <= egress_shared_cong ? port_fc_en : '0;
    end
  end
endmodule

// file: tb/smp_frame_policy_assertions.sv
// checker for the ports of the frame policy block
`timescale 1ns/10ps
module smp_policy_checker
  import smp_pkg::*;
#(
  parameter int NPORTS = 7
)(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [SMP_ADDR_W-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [NPORTS-1:0]     port_fc_en,
  input wire logic                  egress_shared_cong,
  input wire logic                  rx_valid,
  input wire logic [SMP_LEN_W-1:0]  rx_len,
  input wire logic                  rx_tagged,
  input wire logic                  rx_done,
  input wire logic                  rx_pass,
  input wire logic                  tx_coll,
  input wire logic [4:0]            tx_coll_cnt,
  input wire logic                  tx_retry,
  input wire logic                  tx_abort,
  input wire logic                  bp_carrier_mode,
  input wire logic [NPORTS-1:0]     fc_assert
);
  logic [7:0] ctl_a_reg;

  // ------------------------------------------------------------
  // shadow of control a, taken from apb writes
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_a_reg <= SMP_RST_CTRL_A;
    end else if (psel && penable && pwrite && paddr == 14'hcc4) begin
      ctl_a_reg <= pwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_done_cause: assert property (rx_done |-> $past(rx_valid))
    else $error("decision without descriptor");
  a_short_drop: assert property (rx_valid && !ctl_a_reg[0]
    && rx_len < 14'd64 |=> !rx_pass) else $error("short frame passed");
  a_runt_drop: assert property (rx_valid && rx_len < 14'd32
    |=> !rx_pass) else $error("runt frame passed");
  a_std_max: assert property (rx_valid && ctl_a_reg[2:1] == 2'b00
    && rx_len > (rx_tagged ? 14'd1522 : 14'd1518) |=> !rx_pass)
    else $error("oversize frame passed");
  a_nochk_max: assert property (rx_valid && ctl_a_reg[2:1] == 2'b01
    && rx_len > 14'd2000 |=> !rx_pass) else $error("frame over 2000 passed");
  a_jumbo_cap: assert property (rx_valid && rx_len > 14'd9022
    |=> !rx_pass) else $error("frame over jumbo cap passed");
  a_xcol_abort: assert property (tx_coll && tx_coll_cnt >= 5'd16
    && !ctl_a_reg[3] |=> tx_abort && !tx_retry) else $error("no abort");
  a_xcol_retry: assert property (tx_coll && (tx_coll_cnt < 5'd16
    || ctl_a_reg[3]) |=> tx_retry && !tx_abort) else $error("no retry");
  a_bp_style: assert property (1'b1 |=>
    bp_carrier_mode == $past(ctl_a_reg[5]))
    else $error("back pressure style differs from control");
  a_fc_follow: assert property (1'b1 |=> fc_assert ==
    ($past(egress_shared_cong) ? $past(port_fc_en) : '0))
    else $error("flow control outputs wrong");
endmodule

bind smp_frame_policy smp_policy_checker #(.NPORTS(NPORTS)) u_chk (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .port_fc_en,
  .egress_shared_cong, .rx_valid, .rx_len, .rx_tagged, .rx_done, .rx_pass,
  .tx_coll, .tx_coll_cnt, .tx_retry, .tx_abort, .bp_carrier_mode,
  .fc_assert
);

// file: tb/smp_frame_policy_test.sv
// self-checking bench for the frame policy block
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module smp_frame_policy_test
  import smp_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        rx_valid, rx_tagged, rx_bcast, rx_mcast, rx_done, rx_pass;
  logic        egress_shared_cong, tx_coll, tx_retry, tx_abort, bp_mode;
  logic [13:0] paddr, rx_len;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  port_fc_en, fc_assert;
  logic [2:0]  rx_port;
  logic [11:0] rx_vid, rx_vid_out;
  logic [4:0]  tx_coll_cnt;
  int          fails, tests_run;
  typedef struct packed {
    logic [7:0] a; logic [13:0] len; logic tag; logic pass;
  } smp_row_s;
  // control a, length, tagged, expected pass
  smp_row_s rows [15] = '{
    '{8'hf0, 14'd63, 1'b0, 1'b0}, '{8'hf0, 14'd64, 1'b0, 1'b1},
    '{8'hf1, 14'd32, 1'b0, 1'b1}, '{8'hf1, 14'd31, 1'b0, 1'b0},
    '{8'hf0, 14'd1518, 1'b0, 1'b1}, '{8'hf0, 14'd1519, 1'b0, 1'b0},
    '{8'hf0, 14'd1522, 1'b1, 1'b1}, '{8'hf0, 14'd1523, 1'b1, 1'b0},
    '{8'hf2, 14'd2000, 1'b0, 1'b1}, '{8'hf2, 14'd2001, 1'b1, 1'b0},
    '{8'hf6, 14'd3018, 1'b0, 1'b1}, '{8'hf6, 14'd3019, 1'b0, 1'b0},
    '{8'hf4, 14'd3022, 1'b1, 1'b1}, '{8'hf4, 14'd3023, 1'b1, 1'b0},
    '{8'hf4, 14'd9100, 1'b1, 1'b0}};

  smp_frame_policy #(.NPORTS(7), .PERIOD_5MS_CYC(20)) uut (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .port_speed(14'h0000),
    .port_default_vid(84'h106_105_104_103_102_101_100), .port_fc_en,
    .jumbo_limit(14'd3000), .egress_shared_cong, .rx_valid, .rx_port,
    .rx_len, .rx_tagged, .rx_vid, .rx_bcast, .rx_mcast, .rx_done, .rx_pass,
    .rx_vid_out, .tx_coll, .tx_coll_cnt, .tx_retry, .tx_abort,
    .bp_carrier_mode(bp_mode), .fc_assert);

  // apb transfer held until pready
  task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one descriptor, decision looked at in its rx_done cycle
  task automatic frame(input logic [2:0] p, input logic [13:0] l,
                       input logic t, input logic [11:0] v,
                       input logic bc, input logic mc);
    @(posedge clk);
    rx_valid <= 1'b1; rx_port <= p; rx_len <= l; rx_tagged <= t;
    rx_vid <= v; rx_bcast <= bc; rx_mcast <= mc;
    @(posedge clk);
    rx_valid <= 1'b0;
    #1 `CHK("rx_done", 1'b1, rx_done)
  endtask

  task automatic coll(input logic [4:0] c, input logic ab);
    @(posedge clk);
    tx_coll <= 1'b1; tx_coll_cnt <= c;
    @(posedge clk);
    tx_coll <= 1'b0;
    #1 `CHK("tx_abort", ab, tx_abort)
    `CHK("tx_retry", !ab, tx_retry)
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish;
  end

  initial begin
    {psel, penable, pwrite, rx_valid, rx_tagged, rx_bcast, rx_mcast} = '0;
    {egress_shared_cong, tx_coll, paddr, pwdata, rx_port, rx_len} = '0;
    {rx_vid, tx_coll_cnt, port_fc_en} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(0, 14'hcc4, 0); `CHK("ctrl_a", 32'hf0, rd)
    apb(0, 14'hcc8, 0); `CHK("ctrl_b", 32'h0, rd)
    apb(0, 14'hccc, 0); `CHK("rate_lo", 32'h4a, rd)
    apb(0, 14'h0040, 0); `CHK("slverr", 1'b1, err)
    `CHK("bp_mode", 1'b1, bp_mode)
    $display("test registers done");
    foreach (rows[i]) begin
      apb(1, 14'hcc4, rows[i].a);
      frame(0, rows[i].len, rows[i].tag, 12'h5, 0, 0);
      `CHK("rx_pass", rows[i].pass, rx_pass)
    end
    $display("test sizes done");
    apb(1, 14'hcc8, 8'h08);
    frame(2, 14'd100, 1, 12'h0, 0, 0); `CHK("vid", 12'h102, rx_vid_out)
    frame(2, 14'd100, 1, 12'h7, 0, 0); `CHK("vid", 12'h007, rx_vid_out)
    apb(1, 14'hcc8, 8'h00);
    frame(2, 14'd100, 1, 12'h0, 0, 0); `CHK("vid", 12'h000, rx_vid_out)
    $display("test null vid done");
    apb(1, 14'hcc4, 8'hf0);
    egress_shared_cong <= 1'b1;
    port_fc_en <= 7'h01;
    frame(3, 14'd100, 0, 12'h5, 0, 0); `CHK("fair", 1'b0, rx_pass)
    frame(0, 14'd100, 0, 12'h5, 0, 0); `CHK("fair", 1'b1, rx_pass)
    `CHK("fc_assert", 7'h01, fc_assert)
    apb(1, 14'hcc4, 8'he0);
    frame(3, 14'd100, 0, 12'h5, 0, 0); `CHK("unfair", 1'b1, rx_pass)
    @(posedge clk);
    egress_shared_cong <= 1'b0;
    $display("test fair mode done");
    apb(1, 14'hccc, 8'h02);
    for (int k = 0; k < 3; k++) begin
      frame(1, 14'd64, 0, 12'h5, 1, 0); `CHK("storm", k < 2, rx_pass)
    end
    frame(1, 14'd64, 0, 12'h5, 0, 1); `CHK("mc_excl", 1'b1, rx_pass)
    apb(1, 14'hcc4, 8'h90);
    @(posedge clk);
    #1 `CHK("bp_mode", 1'b0, bp_mode)
    for (int k = 0; k < 3; k++) begin
      frame(4, 14'd64, 0, 12'h5, 0, 1); `CHK("mc_in", k < 2, rx_pass)
    end
    repeat (2000) @(posedge clk);
    frame(1, 14'd64, 0, 12'h5, 1, 0); `CHK("restart", 1'b1, rx_pass)
    $display("test storm done");
    coll(5'd16, 1'b1);
    coll(5'd15, 1'b0);
    apb(1, 14'hcc4, 8'h98);
    coll(5'd16, 1'b0);
    $display("test collisions done");
    apb(0, 14'hfc0, 0); `CHK("drop_cnt", 32'h0b, rd)
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(0, 14'hcc4, 0); `CHK("ctrl_a", 32'hf0, rd)
    `CHK("bp_mode", 1'b1, bp_mode)
    $display("test reset done");
    tally_and_finish;
  end
endmodule
